/* rtl/cmp_ctrl.sv */
// Comparator control and status logic with an AHB-Lite register slave.
// Assumes one clock; comparator output and pin levels arrive asynchronously.
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl
  import cmp_ctrl_pkg::*;
(
  input  wire logic        CLK,              // Core clock, 40 MHz
  input  wire logic        RESET,            // Async reset, active high
  input  wire logic        CE,               // Clock enable, freezes state
  input  wire logic        HSEL,             // Slave select
  input  wire logic [31:0] HADDR,            // Byte address
  input  wire logic [1:0]  HTRANS,           // Transfer type
  input  wire logic        HWRITE,           // Write when high
  input  wire logic [2:0]  HSIZE,            // Transfer size
  input  wire logic [31:0] HWDATA,           // Write data
  input  wire logic        HREADY,           // Bus ready
  output logic             HREADYOUT,        // Slave ready
  output logic [31:0]      HRDATA,           // Read data
  output logic             HRESP,            // Always OKAY
  input  wire logic        COMP_RAW,         // Raw analog comparator output
  input  wire logic [1:0]  PIN_DIGITAL_IN,   // Digital level of the two pins
  input  wire logic        CONVERTER_ON,     // Converter enabled
  input  wire logic        GLOBAL_IRQ_EN,    // Core global interrupt enable
  input  wire logic        VECTOR_ACK,       // Core entering comparator vector
  output logic             NEG_USE_CHANNEL,  // Negative input from channel mux
  output logic [2:0]       NEG_CHANNEL,      // Channel for negative input
  output logic             POS_USE_BANDGAP,  // Positive input from reference
  output logic             COMP_POWER_OFF,   // Comparator powered down
  output logic [1:0]       PIN_INPUT_OFF,    // Digital input buffers off
  output logic [1:0]       PORT_PIN_VALUE,   // Port read value of the pins
  output logic             CAPTURE_INPUT,    // To timer capture front end
  output logic             IRQ               // Comparator interrupt request
);

  ctrl_s       ctrl_ff;
  logic        flag_ff;
  logic        mux_en_ff;
  logic [2:0]  chan_ff;
  logic [1:0]  pin_off_ff;
  logic        irq_mask_ff;
  logic        comp_meta_ff;
  logic        comp_sync_ff;
  logic        comp_prev_ff;
  logic [1:0]  pin_meta_ff;
  logic [1:0]  pin_sync_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        neg_use_ff;
  logic [2:0]  neg_chan_ff;
  logic        pos_bg_ff;
  logic        pwr_off_ff;
  logic [1:0]  pin_out_ff;
  logic [1:0]  port_val_ff;
  logic        capture_ff;
  logic        irq_ff;
  logic        hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic        nxt_flag;
  logic        event_hit;
  logic        addr_valid;
  logic        wr_data;
  logic [7:0]  rd_byte;
  logic [7:0]  wbyte;
  logic [2:0]  prime_ff;
  logic        primed;

  // Address phase qualifier
  assign addr_valid = HSEL && HREADY &&
                      (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);
  assign wr_data = wr_pend_ff;
  assign wbyte   = HWDATA[7:0];

  // Two-flop synchronisers for comparator and pin levels
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
      comp_prev_ff <= 1'b0;
      pin_meta_ff  <= 2'h0;
      pin_sync_ff  <= 2'h0;
    end
    else if (CE)
    begin
      comp_meta_ff <= COMP_RAW;
      comp_sync_ff <= comp_meta_ff;
      comp_prev_ff <= comp_sync_ff;
      pin_meta_ff  <= PIN_DIGITAL_IN;
      pin_sync_ff  <= pin_meta_ff;
    end
  end

  // History fill: no edge counts until synchroniser and history hold real
  // samples, so a comparator high at reset release fakes no rising edge
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      prime_ff <= 3'h0;
    else if (CE)
      prime_ff <= {prime_ff[1:0], 1'b1};
  end

  assign primed = prime_ff[2];

  // Edge and toggle detection by selected mode
  always_comb
  begin
    case (ctrl_ff.event_mode)
      MODE_TOGGLE:   event_hit = comp_sync_ff ^ comp_prev_ff;
      MODE_FALL:     event_hit = comp_prev_ff & ~comp_sync_ff;
      MODE_RISE:     event_hit = ~comp_prev_ff & comp_sync_ff;
      default:       event_hit = 1'b0;
    endcase
    if (!primed)
      event_hit = 1'b0;
  end

  // Event flag: set wins over vector and write-one clears
  always_comb
  begin
    nxt_flag = flag_ff;
    if (VECTOR_ACK)
      nxt_flag = 1'b0;
    if (wr_data && (wr_addr_ff == OFS_CTRL_STATUS) && wbyte[BIT_FLAG])
      nxt_flag = 1'b0;
    if (wr_data && (wr_addr_ff == OFS_IRQ_STATUS) && wbyte[BIT_EVENT])
      nxt_flag = 1'b0;
    if (event_hit)
      nxt_flag = 1'b1;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      flag_ff <= RST_CTRL_STATUS[BIT_FLAG];
    else if (CE)
      flag_ff <= nxt_flag;
  end

  // Control fields of the control and status register
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl_ff.comparator_power_off    <= RST_CTRL_STATUS[BIT_POWER_OFF];
      ctrl_ff.bandgap_positive_select <= RST_CTRL_STATUS[BIT_BANDGAP];
      ctrl_ff.comparator_irq_enable   <= RST_CTRL_STATUS[BIT_IRQ_EN];
      ctrl_ff.capture_route_enable    <= RST_CTRL_STATUS[BIT_CAPTURE];
      ctrl_ff.event_mode              <= event_mode_e'(RST_CTRL_STATUS[1:0]);
    end
    else if (CE && wr_data && wr_addr_ff == OFS_CTRL_STATUS)
    begin
      ctrl_ff.comparator_power_off    <= wbyte[BIT_POWER_OFF];
      ctrl_ff.bandgap_positive_select <= wbyte[BIT_BANDGAP];
      ctrl_ff.comparator_irq_enable   <= wbyte[BIT_IRQ_EN];
      ctrl_ff.capture_route_enable    <= wbyte[BIT_CAPTURE];
      ctrl_ff.event_mode              <= event_mode_e'(wbyte[1:0]);
    end
  end

  // Pin disable, mux enable, channel and interrupt mask registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      pin_off_ff  <= RST_PIN_DISABLE;
      mux_en_ff   <= 1'b0;
      chan_ff     <= RST_CHAN;
      irq_mask_ff <= RST_IRQ_MASK;
    end
    else if (CE && wr_data)
    begin
      if (wr_addr_ff == OFS_PIN_DISABLE)
        pin_off_ff <= wbyte[1:0];
      if (wr_addr_ff == OFS_CONV_CTRL_B)
        mux_en_ff <= wbyte[BIT_MUX_EN];
      if (wr_addr_ff == OFS_CONV_CHAN)
        chan_ff <= wbyte[2:0];
      if (wr_addr_ff == OFS_IRQ_MASK)
        irq_mask_ff <= wbyte[BIT_EVENT];
    end
  end

  // Analog routing and pin outputs, all registered
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      neg_use_ff  <= 1'b0;
      neg_chan_ff <= 3'h0;
      pos_bg_ff   <= 1'b0;
      pwr_off_ff  <= 1'b0;
      pin_out_ff  <= 2'h0;
      port_val_ff <= 2'h0;
      capture_ff  <= 1'b0;
    end
    else if (CE)
    begin
      neg_use_ff  <= mux_en_ff & ~CONVERTER_ON;
      neg_chan_ff <= (mux_en_ff & ~CONVERTER_ON) ? chan_ff : 3'h0;
      pos_bg_ff   <= ctrl_ff.bandgap_positive_select;
      pwr_off_ff  <= ctrl_ff.comparator_power_off;
      pin_out_ff  <= pin_off_ff;
      port_val_ff <= pin_sync_ff & ~pin_off_ff;
      capture_ff  <= ctrl_ff.capture_route_enable & comp_sync_ff;
    end
  end

  // Interrupt request, gated by enable, global enable and mask
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      irq_ff <= 1'b0;
    else if (CE)
      irq_ff <= flag_ff & ctrl_ff.comparator_irq_enable &
                GLOBAL_IRQ_EN & irq_mask_ff;
  end

  // Read data mux
  always_comb
  begin
    case (HADDR[7:0])
      OFS_CTRL_STATUS: rd_byte = {ctrl_ff.comparator_power_off,
                                  ctrl_ff.bandgap_positive_select,
                                  comp_sync_ff, flag_ff,
                                  ctrl_ff.comparator_irq_enable,
                                  ctrl_ff.capture_route_enable,
                                  ctrl_ff.event_mode};
      OFS_PIN_DISABLE: rd_byte = {6'h00, pin_off_ff};
      OFS_CONV_CTRL_B: rd_byte = {1'b0, mux_en_ff, 6'h00};
      OFS_CONV_CHAN:   rd_byte = {5'h00, chan_ff};
      OFS_IRQ_STATUS:  rd_byte = {7'h00, flag_ff};
      OFS_IRQ_MASK:    rd_byte = {7'h00, irq_mask_ff};
      default:         rd_byte = 8'h00;
    endcase
  end

  // Bus slave: zero wait states, write taken in the data phase
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h0000_0000;
    end
    else if (CE)
    begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff   <= addr_valid && HWRITE && (HADDR[31:8] == 24'h000000);
      wr_addr_ff   <= HADDR[7:0];
      if (addr_valid && !HWRITE && HADDR[31:8] == 24'h000000)
        hrdata_ff <= {24'h000000, rd_byte};
      else
        hrdata_ff <= 32'h0000_0000;
    end
  end

  assign HREADYOUT       = hreadyout_ff;
  assign HRDATA          = hrdata_ff;
  assign HRESP           = 1'b0;
  assign NEG_USE_CHANNEL = neg_use_ff;
  assign NEG_CHANNEL     = neg_chan_ff;
  assign POS_USE_BANDGAP = pos_bg_ff;
  assign COMP_POWER_OFF  = pwr_off_ff;
  assign PIN_INPUT_OFF   = pin_out_ff;
  assign PORT_PIN_VALUE  = port_val_ff;
  assign CAPTURE_INPUT   = capture_ff;
  assign IRQ             = irq_ff;

  // Helper: raw input held stable across the synchroniser
  sequence raw_steady;
    CE && $stable(COMP_RAW) ##1 CE && $stable(COMP_RAW);
  endsequence

  a_sync_output_latency: assert property (
    @(posedge CLK) disable iff (RESET)
    raw_steady ##1 (CE && primed) |-> comp_sync_ff == $past(COMP_RAW, 2))
    else $error("synchronised output does not follow raw input");

  sequence rise_seen;
    CE && primed && ctrl_ff.event_mode == MODE_RISE && !comp_prev_ff &&
    comp_sync_ff;
  endsequence

  a_rise_sets_flag: assert property (
    @(posedge CLK) disable iff (RESET)
    rise_seen |=> flag_ff)
    else $error("rising edge did not set event flag");

  a_fall_sets_flag: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && primed && ctrl_ff.event_mode == MODE_FALL && comp_prev_ff &&
    !comp_sync_ff
    |=> flag_ff)
    else $error("falling edge did not set event flag");

  a_reserved_mode_silent: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && ctrl_ff.event_mode == MODE_RESERVED && !flag_ff |=> !flag_ff)
    else $error("reserved mode set the event flag");

  a_vector_clears_flag: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && VECTOR_ACK && !event_hit |=> !flag_ff)
    else $error("vector entry did not clear the flag");

  a_write_one_clears: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && wr_data && wr_addr_ff == OFS_CTRL_STATUS && !event_hit &&
    !VECTOR_ACK
    |=> flag_ff == ($past(flag_ff) && !$past(wbyte[BIT_FLAG])))
    else $error("flag write did not act as write-one-to-clear");

  a_irq_gating_all: assert property (
    @(posedge CLK) disable iff (RESET)
    CE |=> IRQ == $past(flag_ff && ctrl_ff.comparator_irq_enable &&
                        GLOBAL_IRQ_EN && irq_mask_ff))
    else $error("interrupt request not gated correctly");

  a_capture_route_off: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && !ctrl_ff.capture_route_enable |=> !CAPTURE_INPUT)
    else $error("comparator reached capture while route off");

  a_negative_input_sel: assert property (
    @(posedge CLK) disable iff (RESET)
    CE |=> NEG_USE_CHANNEL == $past(mux_en_ff && !CONVERTER_ON) &&
           (!NEG_USE_CHANNEL || NEG_CHANNEL == $past(chan_ff)))
    else $error("negative input selection wrong");

  a_pin_read_masked: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && pin_off_ff[0] |=> !PORT_PIN_VALUE[0])
    else $error("disabled pin did not read zero");

  a_second_pin_masked: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && pin_off_ff[1] |=> !PORT_PIN_VALUE[1])
    else $error("disabled negative pin did not read zero");

  sequence toggle_seen;
    CE && primed && ctrl_ff.event_mode == MODE_TOGGLE &&
    comp_prev_ff != comp_sync_ff;
  endsequence

  a_toggle_sets_flag: assert property (
    @(posedge CLK) disable iff (RESET)
    toggle_seen |=> flag_ff)
    else $error("output toggle did not set event flag");

  a_status_write_clears: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && wr_data && wr_addr_ff == OFS_IRQ_STATUS && wbyte[BIT_EVENT] &&
    !event_hit |=> !flag_ff)
    else $error("status write of one did not clear the flag");

  a_dedicated_neg_pin: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && !mux_en_ff |=> !NEG_USE_CHANNEL && NEG_CHANNEL == 3'h0)
    else $error("negative pin not selected with mux enable clear");

  a_bandgap_follows: assert property (
    @(posedge CLK) disable iff (RESET)
    CE |=> POS_USE_BANDGAP == $past(ctrl_ff.bandgap_positive_select))
    else $error("positive input does not follow bandgap bit");

  a_power_off_follows: assert property (
    @(posedge CLK) disable iff (RESET)
    CE |=> COMP_POWER_OFF == $past(ctrl_ff.comparator_power_off))
    else $error("power-off output does not follow its bit");

  a_capture_route_on: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && ctrl_ff.capture_route_enable |=>
    CAPTURE_INPUT == $past(comp_sync_ff))
    else $error("capture input does not follow comparator output");

  a_reserved_reads_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    CE && addr_valid && !HWRITE && HADDR == {24'h000000, OFS_PIN_DISABLE}
    |=> HRDATA[31:2] == 30'h0)
    else $error("reserved pin disable bits did not read zero");

endmodule
`default_nettype wire

/* rtl/cmp_ctrl_pkg.sv */
// Constants, register map and field layout of the comparator control block.
// Assumes a 32-bit AHB-Lite bus with each register in one aligned word.
//
// Notes on behaviour
// - Mux enable set and converter off: converter channel mux drives negative input.
// - Mux enable clear: dedicated negative pin drives the negative input.
// - channel select 000..111 picks channel zero..seven.
// - Writing one to power-off switches the comparator off, at any time.
// - Bandgap select one uses internal reference on positive input, else pin.
// - Raw comparator output is synchronised, one to two cycles, onto status bit.
// - Event flag sets when synchronised output shows the selected event.
// - Event flag clears when the processor enters the matching vector.
// - Writing one to the event flag clears it; writing zero leaves it.
// - Request is high only while flag, enable and global enable are all one.
// - Capture route set feeds comparator output to timer capture front end.
// - Capture route clear disconnects comparator output from timer capture.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Pin input disable turns the buffer off; port bit then reads zero.
// - Upper six bits of the pin input disable register read zero.
package cmp_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFS_PIN_DISABLE = 8'h04;
  localparam logic [7:0] OFS_CONV_CTRL_B = 8'h08;
  localparam logic [7:0] OFS_CONV_CHAN   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
  // Field positions
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_BANDGAP   = 6;
  localparam int BIT_OUTPUT    = 5;
  localparam int BIT_FLAG      = 4;
  localparam int BIT_IRQ_EN    = 3;
  localparam int BIT_CAPTURE   = 2;
  localparam int BIT_MUX_EN    = 6;
  localparam int BIT_EVENT     = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [1:0] RST_PIN_DISABLE = 2'h0;
  localparam logic [2:0] RST_CHAN        = 3'h0;
  localparam logic       RST_IRQ_MASK    = 1'h1;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  // Event mode encodings
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALL     = 2'h2,
    MODE_RISE     = 2'h3
  } event_mode_e;
  // Writable control fields of the control and status register
  typedef struct packed {
    logic        comparator_power_off;
    logic        bandgap_positive_select;
    logic        comparator_irq_enable;
    logic        capture_route_enable;
    event_mode_e event_mode;
  } ctrl_s;
endpackage

/* verif/cmp_ctrl_bench.sv */
// Self-checking bench for the comparator control block over AHB-Lite.
// Assumes the package and the block's top module are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_bench;
  import cmp_ctrl_pkg::*;
  logic        clk;
  logic        reset;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic        comp_raw;
  logic [1:0]  pin_in;
  logic        conv_on;
  logic        gie;
  logic        vec_ack;
  logic        hready;
  logic [31:0] hrdata;
  logic        use_chan;
  logic [2:0]  neg_chan;
  logic        pos_bg;
  logic        pwr_off;
  logic [1:0]  in_off;
  logic [1:0]  port_val;
  logic        cap_in;
  logic        irq;
  logic        ce;
  logic        hresp;
  logic [31:0] rd;
  int          error_cnt;
  int          n_checks;

  // Block under test, its ready fed back as the bus ready
  cmp_ctrl i_dut (
    .CLK(clk), .RESET(reset), .CE(ce), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp),
    .COMP_RAW(comp_raw), .PIN_DIGITAL_IN(pin_in), .CONVERTER_ON(conv_on),
    .GLOBAL_IRQ_EN(gie), .VECTOR_ACK(vec_ack), .NEG_USE_CHANNEL(use_chan),
    .NEG_CHANNEL(neg_chan), .POS_USE_BANDGAP(pos_bg),
    .COMP_POWER_OFF(pwr_off), .PIN_INPUT_OFF(in_off),
    .PORT_PIN_VALUE(port_val), .CAPTURE_INPUT(cap_in), .IRQ(irq)
  );

  // Clock of 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    n_checks++;
    if (got !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One single transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string what);
    xfer(1'b0, a, 8'h00);
    chk(what, {24'h0, e}, rd);
    chk("response", 32'h0, {31'h0, hresp});
  endtask

  // Clear flag at level s with mode m, flip the output, check the flag
  task automatic ev(input logic [1:0] m, input logic s, input logic e);
    comp_raw <= s;
    tick(4);
    xfer(1'b1, OFS_CTRL_STATUS, {6'h04, m});
    comp_raw <= ~s;
    tick(6);
    rdchk(OFS_CTRL_STATUS, {3'h0, e, 2'h0, m} | {2'h0, ~s, 5'h0},
          "event flag");
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  // Main sequence
  initial
  begin
    reset = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    comp_raw = 1'b0;
    pin_in = 2'h3;
    conv_on = 1'b0;
    gie = 1'b0;
    vec_ack = 1'b0;
    ce = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // Reset values and an unmapped place
    rdchk(OFS_CTRL_STATUS, RST_CTRL_STATUS, "ctrl reset");
    rdchk(OFS_PIN_DISABLE, 8'h00, "pin disable reset");
    rdchk(OFS_IRQ_MASK, {7'h0, RST_IRQ_MASK}, "mask reset");
    rdchk(8'h18, 8'h00, "unmapped read");
    // Negative input from every channel code
    xfer(1'b1, OFS_CONV_CTRL_B, 8'h40);
    for (int c = 0; c < 8; c++)
    begin
      xfer(1'b1, OFS_CONV_CHAN, 8'(c));
      tick(3);
      chk("neg select", {29'h1, 3'(c)}, {28'h0, use_chan, neg_chan});
    end
    conv_on <= 1'b1;
    tick(3);
    chk("neg conv on", 32'h0, {28'h0, use_chan, neg_chan});
    conv_on <= 1'b0;
    xfer(1'b1, OFS_CONV_CTRL_B, 8'h00);
    tick(3);
    chk("neg mux off", 32'h0, {28'h0, use_chan, neg_chan});
    // Power-off, bandgap and capture route, interrupt enable clear
    xfer(1'b1, OFS_CTRL_STATUS, 8'hC4);
    comp_raw <= 1'b1;
    tick(6);
    chk("off bandgap route", 32'h7, {29'h0, pwr_off, pos_bg, cap_in});
    rdchk(OFS_CTRL_STATUS, 8'hF4, "ctrl readback");
    xfer(1'b1, OFS_CTRL_STATUS, 8'h10);
    tick(3);
    chk("capture off", 32'h0, {31'h0, cap_in});
    // Every event mode against both edges
    ev(MODE_TOGGLE, 1'b0, 1'b1);
    ev(MODE_TOGGLE, 1'b1, 1'b1);
    ev(MODE_RESERVED, 1'b0, 1'b0);
    ev(MODE_RESERVED, 1'b1, 1'b0);
    ev(MODE_FALL, 1'b0, 1'b0);
    ev(MODE_FALL, 1'b1, 1'b1);
    ev(MODE_RISE, 1'b1, 1'b0);
    ev(MODE_RISE, 1'b0, 1'b1);
    // Interrupt request against its enables, mask and clears
    xfer(1'b1, OFS_CTRL_STATUS, 8'h0B);
    gie <= 1'b1;
    tick(3);
    chk("irq raised", 32'h1, {31'h0, irq});
    gie <= 1'b0;
    tick(3);
    chk("irq global off", 32'h0, {31'h0, irq});
    gie <= 1'b1;
    xfer(1'b1, OFS_IRQ_MASK, 8'h00);
    tick(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, OFS_IRQ_MASK, 8'h01);
    rdchk(OFS_IRQ_STATUS, 8'h01, "irq status");
    @(posedge clk);
    vec_ack <= 1'b1;
    @(posedge clk);
    vec_ack <= 1'b0;
    tick(3);
    chk("irq after vector", 32'h0, {31'h0, irq});
    rdchk(OFS_CTRL_STATUS, 8'h2B, "flag after vector");
    comp_raw <= 1'b0;
    tick(4);
    comp_raw <= 1'b1;
    tick(6);
    chk("irq again", 32'h1, {31'h0, irq});
    // Clock enable low freezes the request against a global disable
    ce <= 1'b0;
    gie <= 1'b0;
    tick(3);
    chk("irq frozen", 32'h1, {31'h0, irq});
    ce <= 1'b1;
    tick(3);
    chk("irq resumed", 32'h0, {31'h0, irq});
    gie <= 1'b1;
    xfer(1'b1, OFS_IRQ_STATUS, 8'h01);
    tick(3);
    chk("irq after clear", 32'h0, {31'h0, irq});
    rdchk(OFS_CTRL_STATUS, 8'h2B, "flag after clear");
    // Pin input buffers and reserved bits
    chk("port value", 32'h3, {30'h0, port_val});
    xfer(1'b1, OFS_PIN_DISABLE, 8'hFF);
    rdchk(OFS_PIN_DISABLE, 8'h03, "pin disable read");
    tick(3);
    chk("pins off", 32'hC, {28'h0, in_off, port_val});
    xfer(1'b1, OFS_PIN_DISABLE, 8'h01);
    tick(3);
    chk("one pin off", 32'h6, {28'h0, in_off, port_val});
    // Reset again in mid-run with the comparator output high
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(6);
    chk("pins after reset", 32'h3, {28'h0, in_off, port_val});
    rdchk(OFS_CTRL_STATUS, 8'h20, "ctrl after reset");
    test_done();
  end
endmodule
`default_nettype wire
